// File: hw/ctg_dev.sv
`timescale 1ns/10ps
module ctg_dev
  import ctg_pkg::*;
#(
  parameter int unsigned CONV_CYCLES  = CTG_CONV_CYCLES,
  parameter int unsigned CAL_CYCLES   = CTG_CAL_CYCLES,
  parameter int unsigned SW_DIV       = CTG_SW_DIV,
  parameter logic [7:0]  CHAN_DEFAULT = CTG_CHAN_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  ctg_if.dev               bus,
  input  wire logic [6:0]  dev_addr,
  input  wire logic [23:0] conv_result,
  output logic [7:0]       channel,
  output logic             converting,
  output logic             conv_start,
  output logic             conv_done,
  output logic             samp_tick,
  output logic             cal_phase
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int SWW = $clog2(SW_DIV + 1);

  ctg_dev_state_e state;    // Bus slave state
  logic           scl_d;    // Clock one cycle ago
  logic           sda_d;    // Data one cycle ago
  logic [2:0]     bitc;     // Bit within byte
  logic [7:0]     sh;       // Incoming byte shifter
  logic           ack_go;   // Acknowledge decision
  logic           rd_mode;  // Addressed for read
  logic [1:0]     byte_cnt; // Result bytes sent
  logic [23:0]    res_sh;   // Outgoing result shifter
  logic [23:0]    result;   // Last finished result
  logic           sda_oe;   // Data pull-down
  logic           wr_acked; // Write acknowledged, held until restart
  logic           rd_active;// Data output phase open
  logic [7:0]     pend;     // Pending channel byte
  logic           pend_valid;
  logic [CW-1:0]  conv_cnt; // Conversion progress
  logic [SWW-1:0] sw_cnt;   // Sampling divider

  // Bus event decoding
  wire scl_rise  = bus.scl & ~scl_d;
  wire scl_fall  = ~bus.scl & scl_d;
  wire start_det = bus.scl & scl_d & sda_d & ~bus.sda;
  wire stop_det  = bus.scl & scl_d & ~sda_d & bus.sda;

  // Address decoding on the eighth bit
  wire [7:0] byte_in  = {sh[6:0], bus.sda};
  wire       own_hit  = (byte_in[7:1] == dev_addr);
  wire       glb_hit  = (byte_in[7:1] == CTG_GLOBAL_ADDR);
  wire       rd_bit   = byte_in[0];
  wire       byte_end = scl_rise & (bitc == 3'd7);

  // Busy device refuses; broadcast read refused
  wire addr_ack = ~converting & (own_hit | (glb_hit & ~rd_bit));

  // Transaction events
  wire addr_take = (state == CTG_S_ADDR) & byte_end & addr_ack;
  wire byte_take = (state == CTG_S_WDATA) & byte_end;
  wire last_rd   = (byte_cnt == 2'(CTG_RES_BYTES - 1));
  wire rd_done   = (state == CTG_S_RACK) & scl_rise & last_rd;

  // Restart on Stop after acked write, or read end
  wire conv_go  = (stop_det & (wr_acked | rd_active)) | rd_done;
  wire conv_end = converting & (conv_cnt == CW'(CONV_CYCLES - 1));
  wire sw_wrap  = (sw_cnt == SWW'(SW_DIV - 1));
  wire cal_next = conv_go | (converting & ~conv_end & (conv_cnt < CW'(CAL_CYCLES - 1)));
  wire [23:0] res_next = {res_sh[22:0], 1'b0};

  // Open-drain data drive
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe;

  // Line history for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= bus.scl;
      sda_d <= bus.sda;
    end
  end

  // Bus slave sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CTG_S_IDLE;
      bitc <= '0;
      sh <= '0;
      ack_go <= 1'b0;
      rd_mode <= 1'b0;
      byte_cnt <= '0;
      res_sh <= '0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      // Start or repeated Start
      state <= CTG_S_ADDR;
      bitc <= '0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      // Stop releases the line
      state <= CTG_S_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        CTG_S_IDLE: begin
        end
        CTG_S_ADDR, CTG_S_WDATA: if (scl_rise) begin
          // Shift in one bit
          sh <= byte_in;
          bitc <= bitc + 1'b1;
          if (bitc == 3'd7) begin
            state <= CTG_S_ACK;
            if (state == CTG_S_ADDR) begin
              ack_go <= addr_ack;
              rd_mode <= rd_bit;
              res_sh <= result;
            end else begin
              // Channel bytes are always taken
              ack_go <= 1'b1;
            end
          end
        end
        CTG_S_ACK: if (scl_fall) begin
          // Drive acknowledge through ninth clock
          sda_oe <= ack_go;
          state <= CTG_S_SLOT;
        end
        CTG_S_SLOT: if (scl_fall) begin
          if (!ack_go) begin
            // Not-acknowledged: ignore until next Start
            sda_oe <= 1'b0;
            state <= CTG_S_IDLE;
          end else if (rd_mode) begin
            // First result bit
            sda_oe <= ~res_sh[23];
            res_sh <= res_next;
            byte_cnt <= '0;
            state <= CTG_S_RBIT;
          end else begin
            sda_oe <= 1'b0;
            state <= CTG_S_WDATA;
          end
        end
        CTG_S_RBIT: begin
          if (scl_rise) begin
            // Master sampled a bit
            bitc <= bitc + 1'b1;
            if (bitc == 3'd7) begin
              state <= CTG_S_RREL;
            end
          end else if (scl_fall) begin
            // Next result bit
            sda_oe <= ~res_sh[23];
            res_sh <= res_next;
          end
        end
        CTG_S_RREL: if (scl_fall) begin
          // Free line for master acknowledge
          sda_oe <= 1'b0;
          state <= CTG_S_RACK;
        end
        CTG_S_RACK: if (scl_rise) begin
          byte_cnt <= byte_cnt + 1'b1;
          if (last_rd || bus.sda) begin
            // All bytes out, or master refused more
            state <= CTG_S_IDLE;
          end else begin
            state <= CTG_S_REND;
          end
        end
        CTG_S_REND: if (scl_fall) begin
          sda_oe <= ~res_sh[23];
          res_sh <= res_next;
          state <= CTG_S_RBIT;
        end
      endcase
    end
  end

  // Transaction flags and pending channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_acked <= 1'b0;
      rd_active <= 1'b0;
      pend <= CHAN_DEFAULT;
      pend_valid <= 1'b0;
    end else if (conv_go) begin
      wr_acked <= 1'b0;
      rd_active <= 1'b0;
      pend_valid <= 1'b0;
    end else begin
      if (addr_take && rd_bit) begin
        rd_active <= 1'b1;
      end
      if (addr_take && !rd_bit) begin
        // Write address acknowledged
        wr_acked <= 1'b1;
      end
      if (byte_take) begin
        // Held until the closing Stop
        pend <= byte_in;
        pend_valid <= 1'b1;
      end
    end
  end

  // Conversion timer and channel commit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      converting <= 1'b1;
      conv_cnt <= '0;
      channel <= CHAN_DEFAULT;
      result <= '0;
      conv_start <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_start <= conv_go;
      conv_done <= conv_end & ~conv_go;
      if (conv_go) begin
        converting <= 1'b1;
        conv_cnt <= '0;
        if (pend_valid) begin
          // New selection, else previous kept
          channel <= pend;
        end
      end else if (conv_end) begin
        // Sleep with result ready
        converting <= 1'b0;
        result <= conv_result;
      end else if (converting) begin
        conv_cnt <= conv_cnt + 1'b1;
      end
    end
  end

  // Sampling switch divider and calibration phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_cnt <= '0;
      samp_tick <= 1'b0;
      cal_phase <= 1'b0;
    end else begin
      cal_phase <= cal_next;
      samp_tick <= converting & ~conv_go & sw_wrap;
      if (!converting || conv_go || sw_wrap) begin
        sw_cnt <= '0;
      end else begin
        sw_cnt <= sw_cnt + 1'b1;
      end
    end
  end
endmodule

// File: hw/ctg_host.sv
`timescale 1ns/10ps
module ctg_host
  import ctg_pkg::*;
#(
  parameter int unsigned QTR_DIV = CTG_QTR_DIV
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  ctg_if.host              bus,
  input  wire logic        cmd_valid,
  input  wire ctg_cmd_e    cmd_kind,
  input  wire logic [6:0]  cmd_addr,
  input  wire logic        cmd_has_byte,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        all_finished,
  output logic             cmd_ready,
  output logic             done,
  output logic             acked,
  output logic [23:0]      rd_data
);
  localparam int QW = $clog2(QTR_DIV + 1);

  ctg_host_state_e state;  // Bus sequencer state
  logic [QW-1:0]   qcnt;   // Quarter-period divider
  logic [1:0]      q;      // Quarter within a bit
  logic [3:0]      bitn;   // Bit within a byte, 8 is ack
  logic [1:0]      byten;  // Byte within transfer
  logic [1:0]      last;   // Index of final byte
  logic [7:0]      tx;     // Outgoing byte
  logic [7:0]      wbyte;  // Held channel byte
  logic            rd;     // Transfer is a read
  logic            ack_ok; // No not-acknowledge seen
  logic            scl_oe; // Clock pull-down
  logic            sda_oe; // Data pull-down
  logic [23:0]     rx_q;   // Read result shifter

  // Decoding of the request and bus phase
  wire        tick     = (qcnt == QW'(QTR_DIV - 1));
  wire        is_sync  = (cmd_kind == CTG_CMD_SYNC);
  wire        is_rd    = (cmd_kind == CTG_CMD_READ);
  wire [6:0]  tgt      = is_sync ? CTG_GLOBAL_ADDR : cmd_addr;
  wire        glb_rd   = is_rd & (cmd_addr == CTG_GLOBAL_ADDR);
  wire        can_go   = ~is_sync | all_finished;
  wire        take     = cmd_valid & cmd_ready & can_go;
  wire        rx_byte  = rd & (byten != 2'd0);
  wire        ack_slot = (bitn == 4'd8);
  wire        end_byte = (byten == last) | ~ack_ok;

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;
  assign rd_data         = rx_q;

  // Quarter-period tick divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qcnt <= '0;
    end else if (tick || state == CTG_H_IDLE) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + 1'b1;
    end
  end

  // Bus sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CTG_H_IDLE;
      q <= '0;
      bitn <= '0;
      byten <= '0;
      last <= '0;
      tx <= '0;
      wbyte <= '0;
      rd <= 1'b0;
      ack_ok <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rx_q <= '0;
      cmd_ready <= 1'b1;
      done <= 1'b0;
      acked <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        CTG_H_IDLE: begin
          if (take && glb_rd) begin
            // Broadcast read refused without bus traffic
            done <= 1'b1;
            acked <= 1'b0;
          end else if (take) begin
            tx <= {tgt, is_rd};
            wbyte <= cmd_byte;
            rd <= is_rd;
            last <= is_rd ? 2'(CTG_RES_BYTES) : {1'b0, cmd_has_byte};
            ack_ok <= 1'b1;
            byten <= '0;
            bitn <= '0;
            q <= '0;
            cmd_ready <= 1'b0;
            state <= CTG_H_START;
          end
        end
        CTG_H_START: if (tick) begin
          // Data falls while clock high, then clock falls
          q <= q + 1'b1;
          if (q == 2'd0) begin
            sda_oe <= 1'b1;
          end else begin
            scl_oe <= 1'b1;
            q <= '0;
            state <= CTG_H_BIT;
          end
        end
        CTG_H_BIT: if (tick) begin
          q <= q + 1'b1;
          unique case (q)
            2'd0: begin
              // Set data while clock low
              if (!ack_slot) begin
                sda_oe <= rx_byte ? 1'b0 : ~tx[7];
              end else begin
                sda_oe <= rx_byte & (byten != last);
              end
            end
            2'd1: scl_oe <= 1'b0;
            2'd2: begin
              // Sample while clock high
              if (!ack_slot && rx_byte) begin
                rx_q <= {rx_q[22:0], bus.sda};
              end else if (ack_slot && !rx_byte && bus.sda) begin
                ack_ok <= 1'b0;
              end
            end
            2'd3: begin
              scl_oe <= 1'b1;
              if (!ack_slot) begin
                tx <= {tx[6:0], 1'b0};
                bitn <= bitn + 1'b1;
              end else if (end_byte) begin
                // Stop only after the ninth clock
                bitn <= '0;
                state <= CTG_H_STOP;
              end else begin
                bitn <= '0;
                byten <= byten + 1'b1;
                tx <= wbyte;
              end
            end
          endcase
        end
        CTG_H_STOP: if (tick) begin
          q <= q + 1'b1;
          unique case (q)
            2'd0: sda_oe <= 1'b1;
            2'd1: scl_oe <= 1'b0;
            2'd2: sda_oe <= 1'b0;
            2'd3: begin
              done <= 1'b1;
              acked <= ack_ok;
              cmd_ready <= 1'b1;
              state <= CTG_H_IDLE;
            end
          endcase
        end
      endcase
    end
  end
endmodule

// File: hw/ctg_if.sv
`timescale 1ns/10ps
// Two-wire bus joining master and converter
interface ctg_if;
  logic host_scl_o;   // Master clock drive level
  logic host_scl_oe;  // Master pulls clock low
  logic host_sda_o;   // Master data drive level
  logic host_sda_oe;  // Master pulls data low
  logic dev_sda_o;    // Converter data drive level
  logic dev_sda_oe;   // Converter pulls data low
  logic scl;          // Resolved clock line
  logic sda;          // Resolved data line

  // Open-drain wired-and with pull-ups
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// File: hw/ctg_pkg.sv
// What this block does
// - After conversion, accept write; result left unread
// - Stop after acked write restarts conversion
// - Channel byte in write used by next conversion
// - Master holds broadcast until all converters finished
// - Broadcast address 1110111 with write is acknowledged
// - Broadcast Stop updates channel, starts all together
// - Bare broadcast Stop keeps channel, starts together
// - Broadcast read gets not-acknowledge
// - Input sampling switches at 123kHz
// - Offset calibration phase in every conversion
// - Own address not-acknowledged while converting
// - Read ends after 24 bits or Stop
// - Default channel used until first write
// - Master aborts read only in ack slot
package ctg_pkg;

  // Broadcast synchronisation address
  localparam logic [6:0] CTG_GLOBAL_ADDR = 7'h77;
  // Channel selection after reset
  localparam logic [7:0] CTG_CHAN_DEFAULT = 8'h00;
  // Result width and bytes
  localparam int CTG_RES_BITS  = 24;
  localparam int CTG_RES_BYTES = 3;

  // System clock rate
  localparam longint CTG_CLK_HZ = 250_000_000;
  // Conversion length in oscillator periods
  localparam longint CTG_CONV_OSC_CLKS = 41036;
  // Internal oscillator rate
  localparam longint CTG_FOSC_HZ = 307_200;
  // Conversion length in system clocks
  localparam int unsigned CTG_CONV_CYCLES = int'(CTG_CLK_HZ * CTG_CONV_OSC_CLKS / CTG_FOSC_HZ);
  // Calibration phase is the first eighth of a conversion
  localparam int unsigned CTG_CAL_CYCLES = CTG_CONV_CYCLES / 8;
  // Sampling switch rate and divider
  localparam longint CTG_SW_HZ = 123_000;
  localparam int unsigned CTG_SW_DIV = int'(CTG_CLK_HZ / CTG_SW_HZ);
  // Bus clock rate and quarter-period divider
  localparam longint CTG_SCL_HZ = 100_000;
  localparam int unsigned CTG_QTR_DIV = int'(CTG_CLK_HZ / (4 * CTG_SCL_HZ));

  // Converter end states
  typedef enum logic [3:0] {
    CTG_S_IDLE, CTG_S_ADDR, CTG_S_WDATA, CTG_S_ACK, CTG_S_SLOT,
    CTG_S_RBIT, CTG_S_RREL, CTG_S_RACK, CTG_S_REND
  } ctg_dev_state_e;

  // Master end states
  typedef enum logic [1:0] {
    CTG_H_IDLE, CTG_H_START, CTG_H_BIT, CTG_H_STOP
  } ctg_host_state_e;

  // Master commands
  typedef enum logic [1:0] {
    CTG_CMD_WRITE, CTG_CMD_READ, CTG_CMD_SYNC
  } ctg_cmd_e;

endpackage

// File: test/ctg_sva.sv
`timescale 1ns/10ps
// Watches the converter end of the two-wire link
module ctg_sva #(
  parameter int CONV_CYCLES = 200,
  parameter int CAL_CYCLES  = 20
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       dev_sda_oe,
  input wire logic [7:0] channel,
  input wire logic       converting,
  input wire logic       conv_start,
  input wire logic       conv_done,
  input wire logic       samp_tick,
  input wire logic       cal_phase
);
  // Window around the conversion length
  localparam int CONV_LO = CONV_CYCLES - 2;
  localparam int CONV_HI = CONV_CYCLES + 2;

  int since;  // Cycles since a conversion began

  // Age of the running conversion, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since <= 0;
    end else if (conv_start) begin
      since <= 1;
    end else if (since < 100000) begin
      since <= since + 1;
    end
  end

  // One clock domain for every property
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_start_busy: assert property (conv_start |-> converting)
    else $error("restart pulse without busy flag");
  a_conv_length: assert property (conv_start |-> ##[CONV_LO:CONV_HI] conv_done)
    else $error("conversion length wrong");
  a_conv_quiet: assert property (conv_start |=> !conv_done [*8])
    else $error("conversion ended too soon");
  a_chan_commit: assert property ($changed(channel) |-> conv_start)
    else $error("channel changed outside a restart");
  a_busy_silent: assert property (converting |-> !dev_sda_oe)
    else $error("converter drove data while busy");
  a_samp_busy: assert property (samp_tick |-> converting || $past(converting))
    else $error("sampling tick while idle");
  a_samp_gap: assert property (samp_tick |=> !samp_tick [*7])
    else $error("sampling ticks too close");
  a_cal_first: assert property (conv_start |=> cal_phase [*8])
    else $error("calibration missing at conversion start");
  a_cal_ends: assert property (conv_done |-> !cal_phase)
    else $error("calibration still active at conversion end");
  a_start_scl: assert property ($fell(sda) && scl |-> ##[1:8] !scl)
    else $error("clock not lowered after start");
  a_cal_length: assert property ($fell(cal_phase) |-> since == CAL_CYCLES)
    else $error("calibration phase length wrong");

  // Main scenarios reached
  c_restart: cover property (conv_start);
  c_chan_new: cover property ($changed(channel));
  c_cal_tick: cover property (samp_tick && cal_phase);
endmodule

// File: test/tb.sv
`timescale 1ns/10ps
// Master and converter joined on one link
module tb
  import ctg_pkg::*;
;
  localparam int          CONV     = 200;          // Shortened conversion
  localparam logic [6:0]  OWN_ADDR = 7'h14;        // Converter address
  localparam logic [23:0] RESULT   = 24'ha1b2c3;   // Fixed conversion result
  logic        clk          = 1'b0;                // System clock
  logic        rstn         = 1'b1;                // Reset, active low, dropped after time zero
  logic        cmd_valid    = 1'b0;                // Command request
  ctg_cmd_e    cmd_kind     = CTG_CMD_WRITE;       // Command kind
  logic [6:0]  cmd_addr     = 7'h00;               // Target address
  logic        cmd_has_byte = 1'b0;                // Channel byte present
  logic [7:0]  cmd_byte     = 8'h00;               // Channel byte
  logic        all_finished = 1'b0;                // Converter idle
  logic        cmd_ready, done, acked, converting, conv_start, conv_done, samp_tick, cal_phase;
  logic [23:0] rd_data;                            // Read result
  logic [7:0]  channel;                            // Active selection
  int          miscompares  = 0;                   // Mismatches
  int          checks_done  = 0;                   // Comparisons
  int          starts       = 0;                   // Restart pulses seen
  int          ncyc;                               // Cycles of last command
  int          s;                                  // Restart count snapshot

  ctg_if bus_if();
  ctg_host #(.QTR_DIV(4)) i_ctg_host (.clk, .rstn, .bus(bus_if.host), .cmd_valid, .cmd_kind, .cmd_addr,
    .cmd_has_byte, .cmd_byte, .all_finished, .cmd_ready, .done, .acked, .rd_data);
  ctg_dev #(.CONV_CYCLES(CONV), .CAL_CYCLES(20), .SW_DIV(8)) i_ctg_dev (.clk, .rstn, .bus(bus_if.dev),
    .dev_addr(OWN_ADDR), .conv_result(RESULT), .channel, .converting, .conv_start, .conv_done, .samp_tick,
    .cal_phase);
  ctg_sva #(.CONV_CYCLES(CONV), .CAL_CYCLES(20)) i_ctg_sva (.clk, .rstn, .scl(bus_if.scl), .sda(bus_if.sda),
    .dev_sda_oe(bus_if.dev_sda_oe), .channel, .converting, .conv_start, .conv_done, .samp_tick, .cal_phase);

  // Clock
  always #2 clk = ~clk;
  // Idle flag for broadcast hold-off
  always @(negedge clk) all_finished <= ~converting;
  // Count restarts
  always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One command, held until done
  task automatic cmd(input ctg_cmd_e k, input logic [6:0] a, input logic hb, input logic [7:0] b);
    @(negedge clk);
    cmd_kind = k;
    cmd_addr = a;
    cmd_has_byte = hb;
    cmd_byte = b;
    cmd_valid = 1'b1;
    ncyc = 0;
    do begin
      @(negedge clk);
      ncyc++;
    end while (done !== 1'b1 && ncyc < 5000);
    cmd_valid = 1'b0;
    if (done !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask

  // Wait for the conversion to finish
  task automatic wait_idle();
    int n;
    for (n = 0; n < 1000 && converting !== 1'b0; n++) @(negedge clk);
    if (converting !== 1'b0) begin
      miscompares++;
      final_report();
    end
    s = starts;
  endtask

  // Write refused during power-up conversion
  task automatic t_busy();
    cmd(CTG_CMD_WRITE, OWN_ADDR, 1'b1, 8'h5a);
    chk(acked, 0);
    chk(channel, CTG_CHAN_DEFAULT);
    chk(starts, 0);
    $display("t_busy finished");
  endtask

  // Write with channel byte restarts
  task automatic t_write();
    wait_idle();
    cmd(CTG_CMD_WRITE, OWN_ADDR, 1'b1, 8'h5a);
    chk(acked, 1);
    chk(channel, 8'h5a);
    chk(starts, s + 1);
    $display("t_write finished");
  endtask

  // Full read restarts, channel kept
  task automatic t_read();
    wait_idle();
    cmd(CTG_CMD_READ, OWN_ADDR, 1'b0, 8'h00);
    chk(rd_data, RESULT);
    chk(starts, s + 1);
    chk(channel, 8'h5a);
    $display("t_read finished");
  endtask

  // Broadcast with channel byte
  task automatic t_sync();
    wait_idle();
    cmd(CTG_CMD_SYNC, 7'h00, 1'b1, 8'h33);
    chk(acked, 1);
    chk(channel, 8'h33);
    chk(starts, s + 1);
    $display("t_sync finished");
  endtask

  // Bare broadcast issued while busy
  task automatic t_sync_bare();
    s = starts;
    cmd(CTG_CMD_SYNC, 7'h00, 1'b0, 8'h00);
    chk(ncyc > CONV, 1);
    chk(acked, 1);
    chk(channel, 8'h33);
    chk(starts, s + 1);
    $display("t_sync_bare finished");
  endtask

  // Broadcast read and foreign address refused
  task automatic t_gread();
    wait_idle();
    cmd(CTG_CMD_READ, CTG_GLOBAL_ADDR, 1'b0, 8'h00);
    chk(acked, 0);
    chk(ncyc, 1);
    cmd(CTG_CMD_WRITE, OWN_ADDR ^ 7'h01, 1'b1, 8'hc4);
    chk(acked, 0);
    chk(channel, 8'h33);
    chk(starts, s);
    $display("t_gread finished");
  endtask

  // Main sequence
  initial begin
    // Falling edge after time zero so the flops really reset
    #1 rstn = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_busy();
    t_write();
    t_read();
    t_sync();
    t_sync_bare();
    t_gread();
    final_report();
  end
endmodule
